// File: rtl/pcrs_regs.sv
`include "pcrs_map.svh"
`default_nettype none

// Behaviour
// - Register clearing may settle up to 5 ms
// - Power-off clears only the addressed channel
// - Class 5+ single signature: both channels off
// - Dual signature channel re-powers on request
// - Reset register: write-only, one-bits act, self-clearing
// - Bit 7 clears events, interrupts, releases pin
// - Bit 6 releases pin, events untouched
// - Released pin stays high until events cleared
// - Bit 4 restores power-up register state
// - Full reset affects only this group
// - Bits 3-0 force channel off immediately
// - 4-pair port: either bit resets both
// - Channel reset reloads policing, clears status bits
// - Channel reset clears measurements and class results
// - Channel reset clearing completes within 5 ms
// - Channel reset aborts running cool-down
// - Identification: maker bits 7-3, revision 2-0
// - Status bits 7-4: auto-class support per channel
// - Status bits 3-2 and 1-0: connection check
// - Check codes: unknown, single, dual, reserved
// - Check field written in the same cycle as detection event release
// - Auto-class measured after turn-on when supported
module pcrs_regs
	import pcrs_pkg::*;
#(
	parameter int P_SETTLE_CYC = `PCRS_SETTLE_MS * `PCRS_CLK_KHZ,
	parameter logic [6:0] P_DEV_ADDR = `PCRS_I2C_ADDR
)(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda_in,
	output var logic o_sda_out,
	output var logic o_sda_oe,
	input wire logic [3:0] i_channel_power_off_bit,
	input wire logic [3:0] i_channel_power_on_bit,
	input wire logic [3:0] i_det_cls_valid,
	input wire logic [3:0] i_alloc_ok,
	input wire logic [1:0] i_four_pair,
	input wire logic [1:0] i_single_sig,
	input wire logic [1:0] i_class_ge5,
	input wire logic i_irq_pending,
	input wire logic [3:0] i_ac_done,
	input wire logic [3:0] i_ac_support,
	input wire logic [1:0] i_cc_done,
	input wire logic [3:0] i_cc_result,
	input wire logic [3:0] i_power_good_rise,
	output var logic o_irq_n,
	output var logic o_clear_events,
	output var logic o_group_reset,
	output var logic [3:0] o_chan_off,
	output var logic [3:0] o_cooldown_abort,
	output var logic [3:0] o_chan_on_req,
	output var logic o_settle_busy,
	output var logic [1:0] o_det_event_go,
	output var logic [3:0] o_ac_measure_start
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Widen a channel mask to both channels of each flagged port
	function automatic logic [3:0] pair_expand(input logic [3:0] b, input logic [1:0] m);
		logic [3:0] r;
		r = b;
		for (int p = 0; p < 2; p++)
		begin
			if (m[p] && (|b[2*p +: 2]))
				r[2*p +: 2] = 2'b11;
		end
		return r;
	endfunction

	// Read data for a command code
	function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] id, input logic [7:0] st);
		logic [7:0] r;
		r = 8'h00;
		if (a == `PCRS_OFS_ID)
			r = id;
		else if (a == `PCRS_OFS_STATUS)
			r = st;
		return r;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [2:0] scl_q;
	logic [2:0] sda_q;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	pcrs_state_e state_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q, ptr_q;
	logic first_q, rw_q;
	logic wr_stb_q;
	logic [7:0] wr_addr_q, wr_data_q;
	logic [7:0] id_q;
	logic [3:0] ac_q, ac_d;
	logic [3:0] cc_q, cc_d;
	logic hold_q;
	logic [19:0] settle_q, settle_d;
	logic rst_wr, full_rst, release_irq;
	logic [3:0] force_d, off_d;
	logic [7:0] rd_now, rd_next;

	// ----------------------------------------
	// Pin synchronisers and bus events
	// ----------------------------------------
	// Two stages before use; third stage for edges
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end
		else
		begin
			scl_q <= {scl_q[1:0], i_scl};
			sda_q <= {sda_q[1:0], i_sda_in};
		end
	end

	assign scl_rise = scl_q[1] & ~scl_q[2];
	assign scl_fall = ~scl_q[1] & scl_q[2];
	assign bus_start = scl_q[1] & sda_q[2] & ~sda_q[1];
	assign bus_stop = scl_q[1] & ~sda_q[2] & sda_q[1];
	assign rd_now = read_reg(ptr_q, id_q, {ac_q, cc_q});
	assign rd_next = read_reg(ptr_q + 8'h01, id_q, {ac_q, cc_q});

	// ----------------------------------------
	// Serial slave
	// ----------------------------------------
	// Open-drain data line: the driven level is always low
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			o_sda_out <= 1'b0;
		else
			o_sda_out <= 1'b0;
	end

	// Address, command byte, data bytes, read-back
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			first_q <= 1'b0;
			rw_q <= 1'b0;
			o_sda_oe <= 1'b0;
			wr_stb_q <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
		end
		else
		begin
			wr_stb_q <= 1'b0;
			if (bus_start)
			begin
				state_q <= ST_ADDR;
				cnt_q <= 4'h0;
				first_q <= 1'b1;
				o_sda_oe <= 1'b0;
			end
			else if (bus_stop)
			begin
				state_q <= ST_IDLE;
				o_sda_oe <= 1'b0;
			end
			else
			begin
				unique case (state_q)
					ST_IDLE: ;
					ST_ADDR, ST_RX:
					begin
						if (scl_rise)
						begin
							sh_q <= {sh_q[6:0], sda_q[1]};
							cnt_q <= cnt_q + 4'h1;
						end
						else if (scl_fall && cnt_q == 4'h8)
						begin
							cnt_q <= 4'h0;
							if (state_q == ST_ADDR)
							begin
								if (sh_q[7:1] == P_DEV_ADDR)
								begin
									state_q <= ST_ACK;
									rw_q <= sh_q[0];
									o_sda_oe <= 1'b1;
								end
								else
									state_q <= ST_IDLE;
							end
							else
							begin
								state_q <= ST_ACK;
								o_sda_oe <= 1'b1;
								if (first_q)
								begin
									ptr_q <= sh_q;
									first_q <= 1'b0;
								end
								else
								begin
									wr_stb_q <= 1'b1;
									wr_addr_q <= ptr_q;
									wr_data_q <= sh_q;
									ptr_q <= ptr_q + 8'h01;
								end
							end
						end
					end
					ST_ACK:
					begin
						if (scl_fall && rw_q)
						begin
							state_q <= ST_TX;
							sh_q <= rd_now;
							o_sda_oe <= ~rd_now[7];
							cnt_q <= 4'h1;
						end
						else if (scl_fall)
						begin
							state_q <= ST_RX;
							o_sda_oe <= 1'b0;
						end
					end
					ST_TX:
					begin
						if (scl_fall && cnt_q == 4'h8)
						begin
							state_q <= ST_RACK;
							o_sda_oe <= 1'b0;
						end
						else if (scl_fall)
						begin
							o_sda_oe <= ~sh_q[6];
							sh_q <= {sh_q[6:0], 1'b0};
							cnt_q <= cnt_q + 4'h1;
						end
					end
					ST_RACK:
					begin
						if (scl_rise && sda_q[1])
							state_q <= ST_IDLE;
						else if (scl_fall)
						begin
							state_q <= ST_TX;
							ptr_q <= ptr_q + 8'h01;
							sh_q <= rd_next;
							o_sda_oe <= ~rd_next[7];
							cnt_q <= 4'h1;
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Reset register decode
	// ----------------------------------------
	// Write-only strobes; zero bits have no effect
	assign rst_wr = wr_stb_q && (wr_addr_q == `PCRS_OFS_RESET);
	assign full_rst = rst_wr && wr_data_q[`PCRS_RST_FULL];
	assign release_irq = rst_wr && (wr_data_q[`PCRS_RST_CLR_ALL] || wr_data_q[`PCRS_RST_REL_IRQ]);
	assign force_d = rst_wr ? pair_expand(wr_data_q[3:0], i_four_pair) : 4'h0;
	// Commanded power-off, widened for high-class single-signature ports
	assign off_d = pair_expand(i_channel_power_off_bit, i_four_pair & i_single_sig & i_class_ge5) | force_d;

	// ----------------------------------------
	// Channel commands
	// ----------------------------------------
	// One-cycle pulses; o_chan_off also clears the channel's state
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_chan_off <= 4'h0;
			o_cooldown_abort <= 4'h0;
			o_chan_on_req <= 4'h0;
			o_clear_events <= 1'b0;
			o_group_reset <= 1'b0;
		end
		else
		begin
			o_chan_off <= off_d;
			o_cooldown_abort <= force_d;
			o_chan_on_req <= i_channel_power_on_bit & i_det_cls_valid & i_alloc_ok & ~off_d;
			o_clear_events <= rst_wr && wr_data_q[`PCRS_RST_CLR_ALL];
			o_group_reset <= full_rst;
		end
	end

	// Settling window after any channel power-off or full reset
	assign settle_d = (|off_d || full_rst) ? 20'(P_SETTLE_CYC) :
		(settle_q != 20'h0_0000) ? settle_q - 20'h0_0001 : 20'h0_0000;

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			settle_q <= 20'h0_0000;
			o_settle_busy <= 1'b0;
		end
		else
		begin
			settle_q <= settle_d;
			o_settle_busy <= (settle_d != 20'h0_0000);
		end
	end

	// ----------------------------------------
	// Interrupt pin
	// ----------------------------------------
	// Held released until pending interrupts drain; release wins
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			hold_q <= 1'b0;
			o_irq_n <= 1'b1;
		end
		else
		begin
			if (release_irq)
				hold_q <= 1'b1;
			else if (!i_irq_pending)
				hold_q <= 1'b0;
			o_irq_n <= ~(i_irq_pending && !hold_q && !release_irq);
		end
	end

	// ----------------------------------------
	// Identification and status
	// ----------------------------------------
	// Identification byte, restored by full reset
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			id_q <= `PCRS_ID_RST;
		else if (full_rst)
			id_q <= `PCRS_ID_RST;
		else if (wr_stb_q && wr_addr_q == `PCRS_OFS_ID)
			id_q <= wr_data_q;
	end

	// Clears first, new results override
	always_comb
	begin
		ac_d = ac_q & ~off_d;
		cc_d = cc_q;
		for (int p = 0; p < 2; p++)
		begin
			if (|off_d[2*p +: 2])
				cc_d[2*p +: 2] = CC_UNKNOWN;
		end
		if (full_rst)
		begin
			ac_d = 4'h0;
			cc_d = 4'h0;
		end
		for (int k = 0; k < 4; k++)
		begin
			if (i_ac_done[k])
				ac_d[k] = i_ac_support[k];
		end
		for (int p = 0; p < 2; p++)
		begin
			if (i_four_pair[p] && i_single_sig[p] && (|i_ac_done[2*p +: 2]))
				ac_d[2*p +: 2] = {2{|(i_ac_done[2*p +: 2] & i_ac_support[2*p +: 2])}};
			if (i_cc_done[p])
				cc_d[2*p +: 2] = i_cc_result[2*p +: 2];
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ac_q <= 4'h0;
			cc_q <= 4'h0;
			o_det_event_go <= 2'h0;
			o_ac_measure_start <= 4'h0;
		end
		else
		begin
			ac_q <= ac_d;
			cc_q <= cc_d;
			o_det_event_go <= i_cc_done;
			o_ac_measure_start <= i_power_good_rise & ac_q;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	clr_all_a: assert property (rst_wr && wr_data_q[7] |=> o_clear_events && o_irq_n)
		else $error("clear-all did not clear and release");
	rel_pin_a: assert property (rst_wr && wr_data_q[6] |=> o_irq_n && !o_clear_events)
		else $error("pin release failed or cleared events");
	irq_hold_a: assert property (hold_q && i_irq_pending |=> o_irq_n)
		else $error("interrupt reasserted while held");
	force_off_a: assert property (rst_wr |=> (o_chan_off & $past(wr_data_q[3:0])) == $past(wr_data_q[3:0]))
		else $error("forced channel not switched off");
	pair_reset_a: assert property (rst_wr && i_four_pair[0] && (|wr_data_q[1:0]) |=> o_chan_off[1:0] == 2'b11)
		else $error("4-pair reset hit one channel only");
	class5_off_a: assert property (i_channel_power_off_bit[0] && i_four_pair[0] && i_single_sig[0] && i_class_ge5[0]
		|=> &o_chan_off[1:0])
		else $error("high class port left half on");
	only_chan_a: assert property (!rst_wr && i_four_pair == 2'b00 |=> o_chan_off == $past(i_channel_power_off_bit))
		else $error("power-off touched another channel");
	full_rst_a: assert property (full_rst |=> o_group_reset ##0 id_q == `PCRS_ID_RST)
		else $error("full reset not applied");
	zero_bits_a: assert property (rst_wr && wr_data_q == 8'h00 |=> !o_clear_events && !o_group_reset && o_chan_off == 4'h0)
		else $error("zero write had an effect");
	settle_a: assert property (|o_chan_off |-> o_settle_busy ##1 o_settle_busy)
		else $error("settle window missing");
	cc_order_a: assert property (i_cc_done[0] |=> o_det_event_go[0] && cc_q[1:0] == $past(i_cc_result[1:0]))
		else $error("check field not written with event release");
	ac_start_a: assert property (i_power_good_rise[0] && ac_q[0] |=> o_ac_measure_start[0])
		else $error("auto-class measurement not started");

	release_wait_c: cover property (rst_wr && wr_data_q[6] ##1 i_irq_pending [*3]);
	status_read_c: cover property (state_q == ST_TX && ptr_q == `PCRS_OFS_STATUS);
	force_off_c: cover property (o_cooldown_abort != 4'h0);

endmodule // pcrs_regs

`default_nettype wire

// File: rtl/pcrs_map.svh
`ifndef PCRS_MAP_SVH
`define PCRS_MAP_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define PCRS_OFS_RESET 8'h1a
`define PCRS_OFS_ID 8'h1b
`define PCRS_OFS_STATUS 8'h1c

// ----------------------------------------
// Reset register bit positions
// ----------------------------------------
`define PCRS_RST_CLR_ALL 7
`define PCRS_RST_REL_IRQ 6
`define PCRS_RST_FULL 4

// ----------------------------------------
// Reset values (identity value is arbitrary)
// ----------------------------------------
`define PCRS_ID_RST 8'h8a
`define PCRS_STATUS_RST 8'h00
`define PCRS_RESET_RST 8'h00
`define PCRS_I2C_ADDR 7'h20

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCRS_CLK_KHZ 125000
`define PCRS_SETTLE_MS 5

`endif

// File: rtl/pcrs_pkg.sv
`default_nettype none

package pcrs_pkg;

	// Serial slave states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_ACK = 6'h04,
		ST_RX = 6'h08,
		ST_TX = 6'h10,
		ST_RACK = 6'h20
	} pcrs_state_e;

	// Connection check result codes
	typedef enum logic [1:0] {
		CC_UNKNOWN = 2'h0,
		CC_SINGLE = 2'h1,
		CC_DUAL = 2'h2,
		CC_RSVD = 2'h3
	} pcrs_cc_e;

endpackage

`default_nettype wire

// File: sim/pcrs_host_model.sv
`include "pcrs_map.svh"
`default_nettype none

// I2C host: SCL idles high and stands still between frames
module pcrs_host_model
(
	input wire logic i_sys_clk,
	input wire logic i_sda,
	output var logic o_scl,
	output var logic o_sda_pull
);
	timeunit 1ns;
	timeprecision 1ps;

	// Bus released at start
	initial
	begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
	end

	// Quarter bit of five clocks, then move both lines
	task automatic q(input logic c, input logic p);
		repeat (5) @(posedge i_sys_clk);
		o_scl <= c;
		o_sda_pull <= p;
	endtask

	// One bit; a one releases SDA, wire level sampled mid-high
	task automatic bit_x(input logic b, output logic r);
		q(1'b0, ~b);
		q(1'b1, ~b);
		q(1'b1, ~b);
		r = i_sda;
		q(1'b0, ~b);
	endtask

	// Start, also repeated start
	task automatic start();
		q(1'b0, 1'b0);
		q(1'b1, 1'b0);
		q(1'b1, 1'b1);
		q(1'b0, 1'b1);
	endtask

	// Stop leaves both lines high
	task automatic stop();
		q(1'b0, 1'b1);
		q(1'b1, 1'b1);
		q(1'b1, 1'b0);
	endtask

	// Eight bits MSB first, then the acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic a9, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r[i]);
		bit_x(a9, a);
		ack = ~a;
	endtask

	// Command then one data byte
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic k0;
		logic k1;
		logic k2;
		start();
		xfer({a, 1'b0}, 1'b1, r, k0);
		xfer(c, 1'b1, r, k1);
		xfer(d, 1'b1, r, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask

	// Pointer write, repeated start, one byte ended by NACK
	task automatic rd(input logic [7:0] c, output logic [7:0] d);
		logic [7:0] r;
		logic k;
		start();
		xfer({`PCRS_I2C_ADDR, 1'b0}, 1'b1, r, k);
		xfer(c, 1'b1, r, k);
		start();
		xfer({`PCRS_I2C_ADDR, 1'b1}, 1'b1, r, k);
		xfer(8'hff, 1'b1, d, k);
		stop();
	endtask
endmodule // pcrs_host_model

`default_nettype wire

// File: sim/pcrs_regs_tb.sv
`include "pcrs_map.svh"
`default_nettype none

module pcrs_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SETTLE = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic scl, pull, sda_out, sda_oe, irq_n, ce, gr, busy, pend, ok;
	logic [3:0] poff, pon, valid, alloc, ac_done, ac_sup, cc_res, pg_rise, off, cda, onq, acs, m;
	logic [1:0] fp, ss, ge5, cc_done, dg;
	logic [7:0] v;
	logic [31:0] rnd = 32'he33f_bd3a;
	logic [19:0] expq[$];
	wire logic sda = ~(pull | (sda_oe & ~sda_out));
	wire logic [19:0] pulses = {ce, gr, off, cda, onq, acs, dg};
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	int brun = 0;

	pcrs_regs #(.P_SETTLE_CYC(SETTLE)) dut_u (
		.i_sys_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.i_channel_power_off_bit(poff), .i_channel_power_on_bit(pon), .i_det_cls_valid(valid),
		.i_alloc_ok(alloc), .i_four_pair(fp), .i_single_sig(ss), .i_class_ge5(ge5), .i_irq_pending(pend),
		.i_ac_done(ac_done), .i_ac_support(ac_sup), .i_cc_done(cc_done), .i_cc_result(cc_res),
		.i_power_good_rise(pg_rise), .o_irq_n(irq_n), .o_clear_events(ce), .o_group_reset(gr),
		.o_chan_off(off), .o_cooldown_abort(cda), .o_chan_on_req(onq), .o_settle_busy(busy),
		.o_det_event_go(dg), .o_ac_measure_start(acs));

	pcrs_host_model host_u (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

	// ------
	// Helpers
	// ------
	initial
		forever #4 clk = ~clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_of_test();
		if (expq.size() != 0)
			fails++;
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic w(input logic [7:0] c, input logic [7:0] d);
		host_u.wr(`PCRS_I2C_ADDR, c, d, ok);
		chk("ack", 20'h0_0001, 20'(ok));
	endtask

	task automatic r(input logic [7:0] c, input logic [7:0] e);
		host_u.rd(c, v);
		chk("read", 20'(e), 20'(v));
	endtask

	// Channel command pulse, spaced past the settle window
	task automatic cmd(input logic [3:0] f, input logic [3:0] n, input logic [19:0] e);
		if (e !== 20'h0_0000)
			expq.push_back(e);
		@(posedge clk);
		poff <= f;
		pon <= n;
		@(posedge clk);
		poff <= 4'h0;
		pon <= 4'h0;
		tick(SETTLE + 4);
	endtask

	// Pulse outputs checked against the oldest note
	always @(posedge clk)
		if (!rst && pulses !== 20'h0_0000)
			chk("pulse", (expq.size() > 0) ? expq.pop_front() : 20'h0_0000, pulses);

	// Length of every settle window
	always @(posedge clk)
		if (busy === 1'b1)
			brun <= brun + 1;
		else if (brun != 0)
		begin
			chk("settle", 20'(SETTLE), 20'(brun));
			brun <= 0;
		end

	// Hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			fails++;
			end_of_test();
		end
	end

	// ------
	// Scenarios
	// ------
	initial
	begin
		{pend, poff, pon, valid, alloc, ac_done, ac_sup, cc_res, pg_rise, fp, ss, ge5, cc_done} = '0;
		tick(8);
		rst <= 1'b0;
		valid <= 4'hf;
		alloc <= 4'hf;
		tick(4);
		r(8'h1a, 8'h00);
		r(8'h1b, `PCRS_ID_RST);
		r(8'h1c, 8'h00);
		r(8'h30, 8'h00);
		rnd = lfsr(rnd);
		w(8'h1b, rnd[7:0]);
		r(8'h1b, rnd[7:0]);
		w(8'h1c, rnd[15:8]);
		r(8'h1c, 8'h00);
		// Every link check code in both fields
		for (int k = 0; k < 4; k++)
		begin
			rnd = lfsr(rnd);
			expq.push_back(20'h0_0003);
			@(posedge clk);
			cc_res <= {2'(3 - k), 2'(k)};
			cc_done <= 2'h3;
			ac_sup <= rnd[3:0];
			ac_done <= 4'hf;
			@(posedge clk);
			cc_done <= 2'h0;
			ac_done <= 4'h0;
			tick(2);
			r(8'h1c, {rnd[3:0], 2'(3 - k), 2'(k)});
		end
		if (rnd[3:0] != 4'h0)
			expq.push_back({14'h0000, rnd[3:0], 2'h0});
		@(posedge clk) pg_rise <= 4'hf;
		@(posedge clk) pg_rise <= 4'h0;
		cmd(4'h4, 4'h0, 20'h1_0000);
		r(8'h1c, {rnd[3], 1'b0, rnd[1:0], 4'h3});
		fp <= 2'h1;
		ss <= 2'h1;
		ge5 <= 2'h1;
		cmd(4'h2, 4'h0, 20'h0_c000);
		r(8'h1c, {rnd[3], 7'h00});
		ss <= 2'h0;
		cmd(4'h2, 4'h0, 20'h0_8000);
		tick(SETTLE);
		cmd(4'h0, 4'h2, 20'h0_0080);
		alloc <= 4'hd;
		cmd(4'h0, 4'h2, 20'h0_0000);
		alloc <= 4'hf;
		cmd(4'h8, 4'h8, 20'h2_0000);
		cmd(4'h3, 4'h0, 20'h0_c000);
		// Each force-off bit; ch0 and ch1 form a four-pair port
		for (int i = 0; i < 4; i++)
		begin
			m = (i < 2) ? 4'h3 : 4'(1 << i);
			expq.push_back({2'h0, m, m, 10'h000});
			w(8'h1a, 8'(1 << i));
		end
		w(8'h1a, 8'h20);
		@(posedge clk) ac_done <= 4'hf;
		@(posedge clk) ac_done <= 4'h0;
		w(8'h1b, 8'h3c);
		expq.push_back(20'h4_0000);
		w(8'h1a, 8'h10);
		r(8'h1b, `PCRS_ID_RST);
		r(8'h1c, 8'h00);
		// Interrupt pin release and clear
		pend <= 1'b1;
		tick(4);
		chk("irq", 20'h0_0000, 20'(irq_n));
		w(8'h1a, 8'h40);
		tick(20);
		chk("irq", 20'h0_0001, 20'(irq_n));
		pend <= 1'b0;
		tick(4);
		pend <= 1'b1;
		tick(4);
		chk("irq", 20'h0_0000, 20'(irq_n));
		expq.push_back(20'h8_0000);
		w(8'h1a, 8'h80);
		chk("irq", 20'h0_0001, 20'(irq_n));
		pend <= 1'b0;
		host_u.wr(`PCRS_I2C_ADDR ^ 7'h01, 8'h1b, 8'h00, ok);
		chk("nack", 20'h0_0000, 20'(ok));
		r(8'h1b, `PCRS_ID_RST);
		tick(10);
		end_of_test();
	end
endmodule // pcrs_regs_tb

`default_nettype wire
